// ===== logic/dtb_top.sv
`timescale 1ns/10ps
module dtb_top #(
    parameter int unsigned RTC_DIV = dtb_pkg::RTC_TICK_CYC // Clocks per clock step
) (
    input  wire logic        clk,              // System clock, 50 MHz
    input  wire logic        rst_b,            // Async reset, active low
    input  wire logic [8:0]  addr,             // Register byte address
    input  wire logic [31:0] wdata,            // Write data
    input  wire logic        wr,               // Write strobe
    input  wire logic        rd,               // Read strobe
    output logic      [31:0] rdata,            // Read data, cycle after rd
    input  wire logic [7:0]  ccp_in,           // Capture/event pins, per half
    output logic      [7:0]  ccp_out,          // Waveform pins, per half
    output logic      [7:0]  ccp_oe,           // Pin drive enable
    output logic             adc_trig,         // Conversion start pulse
    output logic             irq               // Level interrupt
);
    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [3:0][1:0]  cfg;                 // Per-block join / clock mode
        logic [7:0][6:0]  ctl;                 // Per-half control
        logic [7:0][15:0] load;                // Start values
        logic [7:0][15:0] match;               // Compare values
        logic [7:0][15:0] cnt;                 // Live counts
        logic [7:0][15:0] cap;                 // Captured counts
        logic [7:0][7:0]  pre;                 // Prescaler divide values
        logic [7:0][7:0]  pcnt;                // Prescaler counters
        logic [7:0]       pin_d;               // Pin levels one cycle ago
        logic [7:0]       pwm;                 // Waveform outputs
        logic [dtb_pkg::RDIV_W-1:0] rdiv;      // Clock-step divider
        logic             adc;                 // Conversion start
        logic             irq;                 // Interrupt level
        logic [15:0]      st;                  // Sticky events
        logic [15:0]      mask;                // Interrupt mask
        logic [31:0]      rdata;               // Read data
    } dtb_state_t;

    dtb_state_t  s_reg;                        // Registered state
    dtb_state_t  s_next;                       // Next state
    logic [7:0]  pin_q;                        // Synchronised pins
    logic [7:0]  tick;                         // Half counts this cycle
    logic [7:0]  tmo;                          // Half timed out this cycle
    logic [7:0]  capev;                        // Half captured this cycle
    logic [7:0]  pevt;                         // Selected pin edge seen
    logic        rtc_step;                     // One clock step due

    // Address match of a per-half register
    function automatic logic dtb_hit(input logic [8:0] a, input int h,
                                     input logic [5:0] off);
        dtb_hit = (a == 9'(h / 2) * dtb_pkg::BLK_STRIDE + {3'h0, off}
                        + ((h % 2 == 1) ? dtb_pkg::HALF_STEP : 9'h000));
    endfunction : dtb_hit

    // =========================================================
    // Pin synchroniser
    // =========================================================
    // pin events
    dtb_sync #(
        .W     (8)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (ccp_in),
        .q     (pin_q)
    );

    // =========================================================
    // Next-state logic
    // =========================================================
    // Counting first, then software writes override data fields
    always_comb begin
        logic [31:0] wide;                     // Joined count
        logic [31:0] wload;                    // Joined start / match value
        logic [1:0]  md;                       // Mode of the half
        logic        ext;                      // Half counts pin events
        int          a;                        // Half A index
        int          c;                        // Half B index
        wide     = '0;
        wload    = '0;
        md       = '0;
        ext      = 1'b0;
        a        = 0;
        c        = 0;
        s_next   = s_reg;
        tick     = '0;
        tmo      = '0;
        capev    = '0;
        rtc_step = (s_reg.rdiv == '0);
        // Free-running divider; the clock step is a one-cycle enable
        s_next.rdiv = rtc_step ? dtb_pkg::RDIV_W'(RTC_DIV - 1)
                               : s_reg.rdiv - dtb_pkg::RDIV_W'(1);
        // Edge select per half
        for (int h = 0; h < dtb_pkg::NHALF; h++) begin
            pevt[h] = s_reg.ctl[h][dtb_pkg::CTL_FALL] ? (~pin_q[h] & s_reg.pin_d[h])
                                                      : (pin_q[h] & ~s_reg.pin_d[h]);
        end
        s_next.pin_d = pin_q;
        for (int b = 0; b < dtb_pkg::NBLK; b++) begin
            a = 2 * b;
            c = a + 1;
            if (s_reg.cfg[b][dtb_pkg::CFG_JOIN]) begin
                wide  = {s_reg.cnt[c], s_reg.cnt[a]};
                wload = {s_reg.load[c], s_reg.load[a]};
                md    = s_reg.ctl[a][dtb_pkg::CTL_MODE +: 2];
                if (s_reg.ctl[a][dtb_pkg::CTL_EN]) begin
                    if (s_reg.cfg[b][dtb_pkg::CFG_RTC]) begin
                        // Clock counts up; load pair is the alarm value
                        if (rtc_step) begin
                            wide   = wide + 32'h1;
                            tmo[a] = (wide == wload);
                        end
                    end else begin
                        tick[a] = 1'b1;
                        if (wide == '0) begin
                            tmo[a] = 1'b1;
                            if (md == dtb_pkg::MODE_ONESHOT) begin
                                s_next.ctl[a][dtb_pkg::CTL_EN] = 1'b0;
                            end else begin
                                wide = wload;
                            end
                        end else begin
                            // Borrow from low half into high half
                            wide = wide - 32'h1;
                        end
                    end
                end
                s_next.cnt[c] = wide[31:16];
                s_next.cnt[a] = wide[15:0];
                s_next.pwm[a] = s_reg.ctl[a][dtb_pkg::CTL_INV];
                s_next.pwm[c] = s_reg.ctl[c][dtb_pkg::CTL_INV];
            end else begin
                for (int h = a; h <= c; h++) begin
                    md  = s_reg.ctl[h][dtb_pkg::CTL_MODE +: 2];
                    // pin events replace clocks, not in capture
                    ext = s_reg.ctl[h][dtb_pkg::CTL_EXT] && (md != dtb_pkg::MODE_CAPTURE);
                    if (s_reg.ctl[h][dtb_pkg::CTL_EN]) begin
                        if (ext) begin
                            tick[h] = pevt[h];
                        end else begin
                            tick[h] = (s_reg.pcnt[h] == 8'h00);
                            s_next.pcnt[h] = tick[h] ? s_reg.pre[h]
                                                     : s_reg.pcnt[h] - 8'h01;
                        end
                        if (tick[h]) begin
                            if (s_reg.cnt[h] == 16'h0000) begin
                                // Capture timebase wraps quietly
                                tmo[h] = (md != dtb_pkg::MODE_CAPTURE);
                                if (md == dtb_pkg::MODE_ONESHOT) begin
                                    s_next.ctl[h][dtb_pkg::CTL_EN] = 1'b0;
                                end else begin
                                    s_next.cnt[h] = s_reg.load[h];
                                end
                            end else begin
                                s_next.cnt[h] = s_reg.cnt[h] - 16'h0001;
                            end
                        end
                        if (md == dtb_pkg::MODE_CAPTURE && pevt[h]) begin
                            s_next.cap[h] = s_reg.cnt[h];
                            capev[h]      = 1'b1;
                        end
                    end
                    s_next.pwm[h] = ((md == dtb_pkg::MODE_PWM)
                                     && s_reg.ctl[h][dtb_pkg::CTL_EN]
                                     && (s_reg.cnt[h] >= s_reg.match[h]))
                                    ^ s_reg.ctl[h][dtb_pkg::CTL_INV];
                end
            end
        end
        s_next.adc = 1'b0;
        for (int h = 0; h < dtb_pkg::NHALF; h++) begin
            if (tmo[h] && s_reg.ctl[h][dtb_pkg::CTL_ADC]) begin
                s_next.adc = 1'b1;
            end
        end
        // Software writes, one register per strobe
        if (wr) begin
            for (int h = 0; h < dtb_pkg::NHALF; h++) begin
                if (dtb_hit(addr, h, dtb_pkg::OFF_CTL)) begin
                    s_next.ctl[h] = wdata[dtb_pkg::CTL_W-1:0];
                    // Starting the clock clears its count
                    if (h % 2 == 0 && s_reg.cfg[h/2][dtb_pkg::CFG_RTC]
                        && wdata[dtb_pkg::CTL_EN] && !s_reg.ctl[h][dtb_pkg::CTL_EN]) begin
                        s_next.cnt[h]   = dtb_pkg::CNT_RST;
                        s_next.cnt[h+1] = dtb_pkg::CNT_RST;
                    end
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_LOAD)) begin
                    s_next.load[h] = wdata[15:0];
                    // In clock mode the load value is only an alarm
                    if (!(s_reg.cfg[h/2][dtb_pkg::CFG_JOIN]
                          && s_reg.cfg[h/2][dtb_pkg::CFG_RTC])) begin
                        s_next.cnt[h] = wdata[15:0];
                    end
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_MATCH)) begin
                    s_next.match[h] = wdata[15:0];
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_PRE)) begin
                    s_next.pre[h]  = wdata[7:0];
                    s_next.pcnt[h] = wdata[7:0];
                end
            end
            for (int b = 0; b < dtb_pkg::NBLK; b++) begin
                if (addr == 9'(b) * dtb_pkg::BLK_STRIDE + {3'h0, dtb_pkg::OFF_CFG}) begin
                    s_next.cfg[b] = wdata[1:0];
                end
            end
            if (addr == dtb_pkg::ADDR_MASK) begin
                s_next.mask = wdata[15:0];
            end
        end
        // sticky flags, a new event wins over the read clear
        s_next.st = (rd && addr == dtb_pkg::ADDR_STATUS) ? 16'h0000 : s_reg.st;
        for (int h = 0; h < dtb_pkg::NHALF; h++) begin
            s_next.st[2*h + dtb_pkg::ST_TMO] = s_next.st[2*h + dtb_pkg::ST_TMO] | tmo[h];
            s_next.st[2*h + dtb_pkg::ST_CAP] = s_next.st[2*h + dtb_pkg::ST_CAP] | capev[h];
        end
        // Read data; unmapped addresses read zero
        s_next.rdata = '0;
        if (rd) begin
            for (int h = 0; h < dtb_pkg::NHALF; h++) begin
                if (dtb_hit(addr, h, dtb_pkg::OFF_CTL)) begin
                    s_next.rdata = {25'h0, s_reg.ctl[h]};
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_LOAD)) begin
                    s_next.rdata = {16'h0, s_reg.load[h]};
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_MATCH)) begin
                    s_next.rdata = {16'h0, s_reg.match[h]};
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_PRE)) begin
                    s_next.rdata = {24'h0, s_reg.pre[h]};
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_VAL)) begin
                    s_next.rdata = {16'h0, s_reg.cnt[h]};
                end
                if (dtb_hit(addr, h, dtb_pkg::OFF_CAP)) begin
                    s_next.rdata = {16'h0, s_reg.cap[h]};
                end
            end
            for (int b = 0; b < dtb_pkg::NBLK; b++) begin
                if (addr == 9'(b) * dtb_pkg::BLK_STRIDE + {3'h0, dtb_pkg::OFF_CFG}) begin
                    s_next.rdata = {30'h0, s_reg.cfg[b]};
                end
            end
            if (addr == dtb_pkg::ADDR_STATUS) begin
                s_next.rdata = {16'h0, s_reg.st};
            end
            if (addr == dtb_pkg::ADDR_MASK) begin
                s_next.rdata = {16'h0, s_reg.mask};
            end
        end
        s_next.irq = |(s_next.st & s_next.mask);
    end

    // =========================================================
    // State register
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg       <= '0;
            s_reg.cfg   <= {4{dtb_pkg::CFG_RST}};
            s_reg.ctl   <= {8{dtb_pkg::CTL_RST}};
            s_reg.load  <= {8{dtb_pkg::LOAD_RST}};
            s_reg.match <= {8{dtb_pkg::MATCH_RST}};
            s_reg.cnt   <= {8{dtb_pkg::CNT_RST}};
            s_reg.pre   <= {8{dtb_pkg::PRE_RST}};
            s_reg.pcnt  <= {8{dtb_pkg::PRE_RST}};
            s_reg.mask  <= dtb_pkg::MASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    always_comb begin
        for (int h = 0; h < dtb_pkg::NHALF; h++) begin
            ccp_oe[h] = (s_reg.ctl[h][dtb_pkg::CTL_MODE +: 2] == dtb_pkg::MODE_PWM)
                        && !s_reg.cfg[h/2][dtb_pkg::CFG_JOIN];
        end
    end
    assign ccp_out  = s_reg.pwm;
    assign adc_trig = s_reg.adc;
    assign irq      = s_reg.irq;
    assign rdata    = s_reg.rdata;

    // =========================================================
    // Assertions (half 0 of block 0 stands for all)
    // =========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic solo0;                               // Half 0 runs alone
    assign solo0 = !s_reg.cfg[0][dtb_pkg::CFG_JOIN] && s_reg.ctl[0][dtb_pkg::CTL_EN];

    sequence sq_gap2;
        !tick[0] ##1 !tick[0] ##1 tick[0];
    endsequence

    a_irq_level:  assert property (irq == |(s_reg.st & s_reg.mask))
        else $error("interrupt level disagrees with flags");
    a_st_clear:   assert property (rd && addr == dtb_pkg::ADDR_STATUS |=>
        rdata == {16'h0, $past(s_reg.st)})
        else $error("status read data wrong");
    a_oneshot_stop: assert property (disable iff (!rst_b || wr)
        solo0 && tick[0] && s_reg.cnt[0] == 16'h0000
        && s_reg.ctl[0][dtb_pkg::CTL_MODE +: 2] == dtb_pkg::MODE_ONESHOT
        |=> !s_reg.ctl[0][dtb_pkg::CTL_EN] && s_reg.st[dtb_pkg::ST_TMO])
        else $error("one-shot did not stop");
    a_periodic_reload: assert property (disable iff (!rst_b || wr)
        solo0 && tick[0] && s_reg.cnt[0] == 16'h0000
        && s_reg.ctl[0][dtb_pkg::CTL_MODE +: 2] == dtb_pkg::MODE_PERIODIC
        |=> s_reg.cnt[0] == $past(s_reg.load[0]))
        else $error("periodic did not reload");
    a_capture_val: assert property (capev[0] |=>
        s_reg.cap[0] == $past(s_reg.cnt[0]) && s_reg.st[dtb_pkg::ST_CAP])
        else $error("capture value lost");
    a_adc_start:  assert property (tmo[0] && s_reg.ctl[0][dtb_pkg::CTL_ADC]
        |=> adc_trig)
        else $error("conversion start missing");
    a_pre_gap:    assert property (disable iff (!rst_b || wr)
        solo0 && tick[0] && !s_reg.ctl[0][dtb_pkg::CTL_EXT]
        && s_reg.pre[0] == 8'h02 && s_reg.cnt[0] != 16'h0000 |=> sq_gap2)
        else $error("prescaler spacing wrong");
    a_join_borrow: assert property (disable iff (!rst_b || wr)
        s_reg.cfg[0] == 2'h1 && s_reg.ctl[0][dtb_pkg::CTL_EN] && s_reg.cnt[0] != 16'h0000
        |=> s_reg.cnt[1] == $past(s_reg.cnt[1]))
        else $error("high half moved without borrow");
    a_pwm_inv:    assert property (!s_reg.ctl[0][dtb_pkg::CTL_EN] && !s_reg.cfg[0][0]
        && $stable(s_reg.ctl[0]) |=> ccp_out[0] == $past(s_reg.ctl[0][dtb_pkg::CTL_INV]))
        else $error("idle waveform ignores inversion");
endmodule : dtb_top

// ===== logic/dtb_pkg.sv
// =============================================================
// Dual 16-bit timer blocks: shared constants
// =============================================================
package dtb_pkg;
    // =========================================================
    // Structure
    // =========================================================
    localparam int NBLK  = 4;                  // Timer blocks
    localparam int NHALF = 8;                  // 16-bit halves, two per block
    localparam int RDIV_W = 26;                // Width of the clock-tick divider

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 20;         // System clock period
    localparam int RTC_TICK_NS   = 1000000000; // Real-time clock step, one second
    localparam int RTC_TICK_CYC  = RTC_TICK_NS / CLK_PERIOD_NS;

    // =========================================================
    // Register map (byte addresses)
    // =========================================================
    localparam logic [8:0] BLK_STRIDE  = 9'h040; // Distance between blocks
    localparam logic [8:0] HALF_STEP   = 9'h004; // Half B sits one word after A
    localparam logic [5:0] OFF_CFG     = 6'h00;  // Block join / clock mode
    localparam logic [5:0] OFF_CTL     = 6'h04;  // Half control (A), B at +4
    localparam logic [5:0] OFF_LOAD    = 6'h0c;  // Start value / clock match
    localparam logic [5:0] OFF_MATCH   = 6'h14;  // Waveform compare value
    localparam logic [5:0] OFF_PRE     = 6'h1c;  // Prescaler divide value
    localparam logic [5:0] OFF_VAL     = 6'h24;  // Live count, read only
    localparam logic [5:0] OFF_CAP     = 6'h2c;  // Captured count, read only
    localparam logic [8:0] ADDR_STATUS = 9'h100; // Sticky events, read clears
    localparam logic [8:0] ADDR_MASK   = 9'h104; // Interrupt mask

    // =========================================================
    // Fields
    // =========================================================
    localparam int CFG_JOIN  = 0;              // Halves form one 32-bit counter
    localparam int CFG_RTC   = 1;              // Joined counter runs as clock
    localparam int CTL_EN    = 0;              // Counting enable
    localparam int CTL_MODE  = 1;              // Two-bit mode field, low bit
    localparam int CTL_EXT   = 3;              // Count pin events, not clocks
    localparam int CTL_INV   = 4;              // Invert waveform output
    localparam int CTL_ADC   = 5;              // Time-out starts a conversion
    localparam int CTL_FALL  = 6;              // Pin event is the falling edge
    localparam int CTL_W     = 7;              // Control width
    localparam int ST_TMO    = 0;              // Status: time-out of half h
    localparam int ST_CAP    = 1;              // Status: capture of half h

    // =========================================================
    // Modes
    // =========================================================
    localparam logic [1:0] MODE_ONESHOT  = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_CAPTURE  = 2'h2;
    localparam logic [1:0] MODE_PWM      = 2'h3;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [6:0]  CTL_RST   = 7'h00;
    localparam logic [1:0]  CFG_RST   = 2'h0;
    localparam logic [15:0] LOAD_RST  = 16'hffff;
    localparam logic [15:0] MATCH_RST = 16'h0000;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [7:0]  PRE_RST   = 8'h00;
    localparam logic [15:0] MASK_RST  = 16'h0000;
endpackage : dtb_pkg

// ===== logic/dtb_sync.sv
`timescale 1ns/10ps
// =============================================================
// Two-stage synchroniser for the pin inputs
// =============================================================
module dtb_sync #(
    parameter int W = 8                        // Number of pins
) (
    input  wire logic         clk,             // System clock
    input  wire logic         rst_b,           // Async reset, active low
    input  wire logic [W-1:0] d,               // Asynchronous pin levels
    output logic      [W-1:0] q                // Levels safe to use
);
    logic [W-1:0] meta_reg;                    // First stage, feeds q only

    // Plain two-flop chain; nothing else looks at the first stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : dtb_sync

// ===== verification/dtb_event_src.sv
`timescale 1ns/10ps
// ==========================================
// Outside event source on the timer pins
module dtb_event_src (
    output logic [7:0] pins // Pin levels, low between events
);
    initial pins = 8'h00;
    task automatic pulse(input int h, input int len);
        pins[h] <= 1'b1;
        #(len);
        pins[h] <= 1'b0;
    endtask : pulse
endmodule : dtb_event_src

// ===== verification/dtb_top_bench.sv
`timescale 1ns/10ps
// ==========================================
// Bench: strobe driver, reads checked from a queue
module dtb_top_bench;
    logic        clk, rst_b, wr, rd, rd_q, adc_trig, irq; // Clock, reset, strobes
    logic [8:0]  addr;                                    // Register address
    logic [31:0] wdata, rdata, v;                         // Bus data, scratch
    logic [31:0] exp_q[$];                                // Expected reads, oldest first
    logic [7:0]  ccp_in, ccp_out, ccp_oe;                 // Timer pins
    int          fails = 0, checks_done = 0, i;           // Tallies, loop index
    // Short clock step keeps the run small
    dtb_top #(.RTC_DIV(4)) dtb_top_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ccp_in(ccp_in),
        .ccp_out(ccp_out), .ccp_oe(ccp_oe), .adc_trig(adc_trig), .irq(irq));
    dtb_event_src dtb_event_src_inst (.pins(ccp_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, want);
        end
    endtask : chk_word
    task automatic chk_pin(input logic got, input logic want);
        chk_word({31'h0, got}, {31'h0, want});
    endtask : chk_pin
    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    // Note the answer first, so the watcher can pair it
    task automatic rd_reg(input logic [8:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask : rd_reg
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) if (rd_q === 1'b1) chk_word(rdata, exp_q.pop_front());
    task automatic final_report;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Hang guard, far beyond the expected run
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        {wr, rd, addr, wdata, rst_b} = '0;
        v = $urandom(32308);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Every block keeps its own start value
        for (i = 0; i < 4; i++) begin
            v = {16'h0000, 16'($urandom)};
            rd_reg(9'(i * 64 + 12), 32'h0000ffff);
            wr_reg(9'(i * 64 + 12), v);
            rd_reg(9'(i * 64 + 36), v);
        end
        rd_reg(9'h1f0, 32'h00000000);
        // One-shot divided by three, conversion start, masked-in flag
        wr_reg(9'h104, 32'h1);
        wr_reg(9'h01c, 32'h2);
        wr_reg(9'h00c, 32'h2);
        wr_reg(9'h004, 32'h21);
        for (i = 0; i < 40 && adc_trig !== 1'b1; i++) @(negedge clk);
        chk_pin(adc_trig, 1'b1);
        rd_reg(9'h004, 32'h20);
        rd_reg(9'h024, 32'h0);
        chk_pin(irq, 1'b1);
        rd_reg(9'h100, 32'h1);
        repeat (2) @(negedge clk);
        chk_pin(irq, 1'b0);
        // Inverted waveform, then plain
        wr_reg(9'h094, 32'h0);
        wr_reg(9'h08c, 32'h5);
        wr_reg(9'h084, 32'h17);
        repeat (4) @(negedge clk);
        chk_pin(ccp_oe[4], 1'b1);
        chk_pin(ccp_out[4], 1'b0);
        wr_reg(9'h084, 32'h07);
        repeat (4) @(negedge clk);
        chk_pin(ccp_out[4], 1'b1);
        wr_reg(9'h084, 32'h0);
        // Periodic half B, one tick per 256 clocks
        wr_reg(9'h060, 32'hff);
        wr_reg(9'h050, 32'h0);
        wr_reg(9'h048, 32'h3);
        repeat (300) @(negedge clk);
        rd_reg(9'h048, 32'h3);
        rd_reg(9'h100, 32'h140);
        wr_reg(9'h048, 32'h0);
        // Rising pin edge captured on the last half
        wr_reg(9'h0c8, 32'h5);
        dtb_event_src_inst.pulse(7, 200);
        repeat (4) @(negedge clk);
        rd_reg(9'h100, 32'h8000);
        repeat (2) @(negedge clk);
        // Joined down-count borrows from the low half, four clocks run
        wr_reg(9'h000, 32'h1);
        wr_reg(9'h010, 32'h1);
        wr_reg(9'h00c, 32'h2);
        wr_reg(9'h004, 32'h1);
        repeat (2) @(posedge clk);
        wr_reg(9'h004, 32'h0);
        rd_reg(9'h028, 32'h0);
        rd_reg(9'h024, 32'hfffe);
        // Joined clock: alarm at two steps
        wr_reg(9'h000, 32'h3);
        wr_reg(9'h00c, 32'h2);
        wr_reg(9'h010, 32'h0);
        wr_reg(9'h004, 32'h1);
        repeat (12) @(negedge clk);
        rd_reg(9'h100, 32'h1);
        wr_reg(9'h004, 32'h0);
        wr_reg(9'h000, 32'h0);
        // Periodic half 0 keeps running after time-outs
        wr_reg(9'h00c, 32'h1);
        wr_reg(9'h004, 32'h3);
        repeat (12) @(negedge clk);
        rd_reg(9'h004, 32'h3);
        wr_reg(9'h004, 32'h0);
        rd_reg(9'h100, 32'h1);
        // Pin events counted on half 6, falling edge captured on half 7
        wr_reg(9'h0cc, 32'h5);
        wr_reg(9'h0c4, 32'h0b);
        wr_reg(9'h0c8, 32'h45);
        dtb_event_src_inst.pulse(6, 100);
        repeat (5) @(posedge clk);
        dtb_event_src_inst.pulse(6, 100);
        dtb_event_src_inst.pulse(7, 100);
        repeat (5) @(posedge clk);
        rd_reg(9'h0e4, 32'h3);
        rd_reg(9'h100, 32'h8000);
        repeat (2) @(negedge clk);
        final_report();
    end
endmodule : dtb_top_bench
